/* core/scl_cmd_if.sv */
// Accepted-command event passed from the register bank to the reset tracker
`timescale 1ns/1ps
`default_nettype none
interface scl_cmd_if;
    logic       valid;
    logic       lock_wr;
    logic [1:0] code;
    modport src (output valid, output lock_wr, output code);
    modport seq (input valid, input lock_wr, input code);
endinterface
`default_nettype wire

/* core/scl_edc.sv */
// Error detection code over the init lock, supply report and OTP commit register bits
`timescale 1ns/1ps
`default_nettype none
module scl_edc
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Guarded contents
    input  wire logic        enable,
    input  wire logic [15:0] data,
    // Sticky mismatch flag
    output logic             fault
);
    import scl_pkg::*;

    logic [7:0] ref_code;
    logic       armed;
    logic [7:0] now_code;

    // Bitwise CRC-8 over the guarded word
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? EDC_POLY : 8'h00);
        return c;
    endfunction

    assign now_code = crc8(data);

    // Reference is taken once when guarding starts
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            armed    <= 1'b0;
            ref_code <= 8'h00;
        end
        else if (enable && !armed)
        begin
            armed    <= 1'b1;
            ref_code <= now_code;
        end
    end

    // Continuous compare; stays set until device reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            fault <= 1'b0;
        else if (armed && now_code != ref_code)
            fault <= 1'b1;
    end

    property p_mismatch;
        @(posedge clk) disable iff (!rstn)
        armed && now_code != ref_code |=> fault;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("code mismatch not flagged");

endmodule // scl_edc
`default_nettype wire

/* core/scl_pkg.sv */
// Shared constants and types of the sensor lock and configuration registers
package scl_pkg;

    localparam int DW = 8;

    // Register offsets
    localparam logic [7:0] ADDR_REV  = 8'h05;
    localparam logic [7:0] ADDR_TEMP = 8'h0e;
    localparam logic [7:0] ADDR_LOCK = 8'h10;
    localparam logic [7:0] ADDR_OTP  = 8'h11;

    // Lock register fields
    localparam int LOCK_INIT_BIT = 7;
    localparam int LOCK_SUP_BIT  = 3;
    localparam int LOCK_CODE_HI  = 1;
    localparam int LOCK_CODE_LO  = 0;

    // OTP commit register fields
    localparam int OTP_TRIG_BIT  = 7;
    localparam int OTP_SKIP_PROTO_BIT = 3;
    localparam int OTP_SKIP_LOC_BIT   = 2;
    localparam int OTP_REG_HI    = 1;
    localparam int OTP_REG_LO    = 0;
    localparam logic [7:0] OTP_WMASK = 8'h8f;

    // Reset values and revision codes
    localparam logic [7:0] LOCK_RESET = 8'h00;
    localparam logic [7:0] OTP_RESET  = 8'h00;
    localparam logic [3:0] REV_DSI3   = 4'h1;
    localparam logic [3:0] REV_PSI5   = 4'h6;

    // Soft reset code sequence, reserved region and EDC polynomial
    localparam logic [1:0] RST_CODE_1  = 2'h0;
    localparam logic [1:0] RST_CODE_2  = 2'h3;
    localparam logic [1:0] RST_CODE_3  = 2'h1;
    localparam logic [1:0] REGION_RSVD = 2'h3;
    localparam logic [7:0] EDC_POLY    = 8'h07;

    typedef enum logic [1:0] {
        SCL_SEQ_IDLE = 2'h0,
        SCL_SEQ_GOT1 = 2'h1,
        SCL_SEQ_GOT2 = 2'h3
    } scl_seq_t;

endpackage

/* core/scl_regs.sv */
// Lock, reset and OTP commit register bank of the pressure sensor
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module scl_regs
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rstn,
    // Operating mode
    input  wire logic                     mode_dsi3,
    input  wire logic                     mode_psi5,
    input  wire logic                     psi5_diag,
    input  wire logic                     psi5_init3_exit,
    // Status sources
    input  wire logic [scl_pkg::DW-1:0]   temp_value,
    input  wire logic                     osc_err_in,
    // Command port
    input  wire logic                     cmd_valid,
    input  wire logic                     cmd_write,
    input  wire logic [7:0]               cmd_addr,
    input  wire logic [scl_pkg::DW-1:0]   cmd_wdata,
    // Response port
    output logic                          rsp_valid,
    output logic                          rsp_hit,
    output logic [scl_pkg::DW-1:0]        rsp_data,
    // Device controls
    output logic                          init_done_lock,
    output logic                          supply_fault_report_off,
    output logic                          baseline_filter_final,
    output logic                          selftest_inhibit,
    output logic                          pdcm_force,
    output logic                          osc_training_fault,
    output logic                          soft_reset_req,
    output logic                          edc_fault,
    // OTP commit
    output logic                          otp_commit_start,
    output logic [1:0]                    otp_region_select,
    output logic                          skip_protocol_select,
    output logic                          skip_location_code,
    output logic [2:0]                    region_locked
);
    import scl_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Command qualification

    logic       access_ok;
    logic       take;
    logic       wr;
    logic       lock_wr;
    logic       otp_wr;
    logic       commit_ok;
    logic [1:0] soft_reset_code;
    logic [7:0] otp_ctrl;
    logic [7:0] temp_reg;
    logic [7:0] lock_view;
    logic [7:0] rd_mux;
    logic       rd_hit;

    scl_cmd_if cmd_bus ();

    // Outside the two access modes the bank stays silent
    assign access_ok = mode_dsi3 | psi5_diag;
    // Once locked in DSI3 the command mode is over, even for reset writes
    assign take      = cmd_valid && access_ok && !(mode_dsi3 && init_done_lock);
    assign wr        = take && cmd_write;
    assign lock_wr   = wr && cmd_addr == ADDR_LOCK;
    assign otp_wr    = wr && cmd_addr == ADDR_OTP && !init_done_lock;
    // Reserved region and already locked regions never start a commit
    assign commit_ok = otp_wr && cmd_wdata[OTP_TRIG_BIT]
                       && cmd_wdata[OTP_REG_HI:OTP_REG_LO] != REGION_RSVD
                       && !region_locked[cmd_wdata[OTP_REG_HI:OTP_REG_LO]];

    //////////////////////////////////////////////////////////////////////////
    // Lock register

    // Init lock: set by write or PSI5 phase 3 exit, cleared only by reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            init_done_lock <= LOCK_RESET[LOCK_INIT_BIT];
        else if (lock_wr && cmd_wdata[LOCK_INIT_BIT])
            init_done_lock <= 1'b1;
        else if (mode_psi5 && psi5_init3_exit)
            init_done_lock <= 1'b1;
    end

    // Supply report switch freezes with the lock
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            supply_fault_report_off <= LOCK_RESET[LOCK_SUP_BIT];
        else if (lock_wr && !init_done_lock)
            supply_fault_report_off <= cmd_wdata[LOCK_SUP_BIT];
    end

    // Reset code bits stay writable after the lock, except in DSI3 mode where the lock ends all commands
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            soft_reset_code <= LOCK_RESET[LOCK_CODE_HI:LOCK_CODE_LO];
        else if (lock_wr)
            soft_reset_code <= cmd_wdata[LOCK_CODE_HI:LOCK_CODE_LO];
    end

    // Side effects of the lock, each on its own flop
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            baseline_filter_final <= 1'b0;
            selftest_inhibit      <= 1'b0;
            pdcm_force            <= 1'b0;
        end
        else
        begin
            baseline_filter_final <= init_done_lock;
            selftest_inhibit      <= init_done_lock;
            pdcm_force            <= init_done_lock && mode_dsi3;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // OTP commit register

    // Bit 7 stays set after a commit, as software reads it back
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            otp_ctrl <= OTP_RESET;
        else if (otp_wr)
            otp_ctrl <= cmd_wdata & OTP_WMASK;
    end

    // Commit pulse with the region and skip bits of the same write
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            otp_commit_start     <= 1'b0;
            otp_region_select    <= OTP_RESET[OTP_REG_HI:OTP_REG_LO];
            skip_protocol_select <= OTP_RESET[OTP_SKIP_PROTO_BIT];
            skip_location_code   <= OTP_RESET[OTP_SKIP_LOC_BIT];
        end
        else
        begin
            otp_commit_start <= commit_ok;
            if (commit_ok)
            begin
                otp_region_select    <= cmd_wdata[OTP_REG_HI:OTP_REG_LO];
                skip_protocol_select <= cmd_wdata[OTP_SKIP_PROTO_BIT];
                skip_location_code   <= cmd_wdata[OTP_SKIP_LOC_BIT];
            end
        end
    end

    // Region lock bits; the cells themselves are written by the OTP engine
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            region_locked <= 3'h0;
        else if (commit_ok)
            region_locked[cmd_wdata[OTP_REG_HI:OTP_REG_LO]] <= 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // Status capture and read path

    // Status inputs registered so the outputs come from flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            temp_reg           <= 8'h00;
            osc_training_fault <= 1'b0;
        end
        else
        begin
            temp_reg           <= temp_value;
            osc_training_fault <= osc_err_in;
        end
    end

    assign lock_view = {init_done_lock, 3'h0, supply_fault_report_off, 1'b0,
                        soft_reset_code};

    // Read mux; unmapped offsets answer with a miss and zero data
    always_comb
    begin
        rd_mux = 8'h00;
        rd_hit = 1'b1;
        case (cmd_addr)
            ADDR_REV:  rd_mux = {4'h0, mode_dsi3 ? REV_DSI3 : REV_PSI5};
            ADDR_TEMP: rd_mux = temp_reg;
            ADDR_LOCK: rd_mux = lock_view;
            ADDR_OTP:  rd_mux = otp_ctrl;
            default:   rd_hit = 1'b0;
        endcase
    end

    // One response per taken command, one cycle later
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rsp_valid <= 1'b0;
            rsp_hit   <= 1'b0;
            rsp_data  <= 8'h00;
        end
        else
        begin
            rsp_valid <= take;
            rsp_hit   <= take && rd_hit;
            if (take && cmd_write && cmd_addr == ADDR_REV)
                rsp_data <= 8'h00;
            else if (take)
                rsp_data <= rd_mux;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Reset tracker and error detection

    assign cmd_bus.valid   = take;
    assign cmd_bus.lock_wr = lock_wr;
    assign cmd_bus.code    = cmd_wdata[LOCK_CODE_HI:LOCK_CODE_LO];

    scl_reset_seq u_reset_seq
    (
        .clk            (clk),
        .rstn           (rstn),
        .cmd            (cmd_bus),
        .soft_reset_req (soft_reset_req)
    );

    // Guarding starts with the lock or with the first committed region
    scl_edc u_edc
    (
        .clk    (clk),
        .rstn   (rstn),
        .enable (init_done_lock || |region_locked),
        .data   ({init_done_lock, supply_fault_report_off, 6'h00, otp_ctrl}),
        .fault  (edc_fault)
    );

    //////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Only from edges out of reset: the flop is held at zero while its source may be high
    property p_osc;
        rstn |=> osc_training_fault == $past(osc_err_in);
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator fault bit does not follow its source");

    property p_rev_read;
        take && !cmd_write && cmd_addr == ADDR_REV
        |=> rsp_data[7:4] == 4'h0 && rsp_data[3:0] == ($past(mode_dsi3) ? REV_DSI3 : REV_PSI5);
    endproperty
    a_rev_read: assert property (p_rev_read)
        else $error("revision read value wrong");

    property p_rev_write;
        take && cmd_write && cmd_addr == ADDR_REV |=> rsp_valid && rsp_data == 8'h00;
    endproperty
    a_rev_write: assert property (p_rev_write)
        else $error("revision write not answered with zero");

    property p_no_access;
        cmd_valid && !access_ok |=> !rsp_valid;
    endproperty
    a_no_access: assert property (p_no_access)
        else $error("answered outside the access modes");

    property p_lock_freeze;
        init_done_lock |=> $stable(otp_ctrl) && $stable(supply_fault_report_off);
    endproperty
    a_lock_freeze: assert property (p_lock_freeze)
        else $error("register changed after init lock");

    property p_init_sticky;
        init_done_lock |=> init_done_lock [*8];
    endproperty
    a_init_sticky: assert property (p_init_sticky)
        else $error("init lock cleared without reset");

    property p_psi5_lock;
        mode_psi5 && psi5_init3_exit |=> init_done_lock ##1 selftest_inhibit;
    endproperty
    a_psi5_lock: assert property (p_psi5_lock)
        else $error("phase 3 exit did not lock");

    property p_crm_off;
        mode_dsi3 && init_done_lock && cmd_valid |=> !rsp_valid;
    endproperty
    a_crm_off: assert property (p_crm_off)
        else $error("command answered after DSI3 lock");

    sequence s_commit_write;
        otp_wr && cmd_wdata[OTP_TRIG_BIT] && cmd_wdata[1:0] != REGION_RSVD
        && !region_locked[cmd_wdata[1:0]];
    endsequence

    property p_commit;
        s_commit_write |=> otp_commit_start && region_locked[otp_region_select];
    endproperty
    a_commit: assert property (p_commit)
        else $error("commit write did not start and lock region");

    property p_no_recommit;
        otp_commit_start |-> (($past(region_locked) >> otp_region_select) & 3'h1) == 3'h0;
    endproperty
    a_no_recommit: assert property (p_no_recommit)
        else $error("commit to an already locked region");

endmodule // scl_regs
`default_nettype wire

/* core/scl_reset_seq.sv */
// Three-write soft reset code tracker
`timescale 1ns/1ps
`default_nettype none
module scl_reset_seq
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Accepted commands
    scl_cmd_if.seq    cmd,
    // Reset request
    output logic      soft_reset_req
);
    import scl_pkg::*;

    scl_seq_t state;
    scl_seq_t next_state;

    // Any command other than the expected one restarts the sequence
    always_comb
    begin
        next_state = state;
        if (cmd.valid)
        begin
            case (state)
                SCL_SEQ_IDLE: next_state = (cmd.lock_wr && cmd.code == RST_CODE_1)
                                           ? SCL_SEQ_GOT1 : SCL_SEQ_IDLE;
                SCL_SEQ_GOT1: next_state = (cmd.lock_wr && cmd.code == RST_CODE_2)
                                           ? SCL_SEQ_GOT2 : SCL_SEQ_IDLE;
                SCL_SEQ_GOT2: next_state = SCL_SEQ_IDLE;
                default:      next_state = SCL_SEQ_IDLE;
            endcase
        end
    end

    // Tracker state
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state <= SCL_SEQ_IDLE;
        else
            state <= next_state;
    end

    // Only the third write in order fires the reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            soft_reset_req <= 1'b0;
        else
            soft_reset_req <= cmd.valid && state == SCL_SEQ_GOT2 && cmd.lock_wr
                              && cmd.code == RST_CODE_3;
    end

    sequence s_third_write;
        state == SCL_SEQ_GOT2 ##0 cmd.valid && cmd.lock_wr && cmd.code == RST_CODE_3;
    endsequence

    property p_reset_fire;
        @(posedge clk) disable iff (!rstn)
        s_third_write |=> soft_reset_req;
    endproperty
    a_reset_fire: assert property (p_reset_fire)
        else $error("third reset code write did not fire reset");

    property p_reset_only_after_two;
        @(posedge clk) disable iff (!rstn)
        soft_reset_req |-> $past(state) == SCL_SEQ_GOT2;
    endproperty
    a_reset_only_after_two: assert property (p_reset_only_after_two)
        else $error("reset fired without the two preceding writes");

    property p_restart;
        @(posedge clk) disable iff (!rstn)
        cmd.valid && !cmd.lock_wr |=> state == SCL_SEQ_IDLE;
    endproperty
    a_restart: assert property (p_restart)
        else $error("foreign command did not restart reset tracking");

endmodule // scl_reset_seq
`default_nettype wire

/* sim/scl_master.sv */
// Behavioural bus master model issuing commands to the register bank
`timescale 1ns/1ps
`default_nettype none
module scl_master
(
    // Clock
    input  wire logic                   clk,
    // Command port
    output logic                        cmd_valid,
    output logic                        cmd_write,
    output logic [7:0]                  cmd_addr,
    output logic [scl_pkg::DW-1:0]      cmd_wdata,
    // Response port
    input  wire logic                   rsp_valid,
    input  wire logic                   rsp_hit,
    input  wire logic [scl_pkg::DW-1:0] rsp_data
);
    import scl_pkg::*;

    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr  = 8'h00;
        cmd_wdata = 8'h00;
    end

    // One command; on release address and data lines show inverted values so stale data never looks valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic got, output logic hit, output logic [7:0] q);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr  <= a;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_addr  <= ~a;
        cmd_wdata <= ~d;
        #1;
        got = rsp_valid;
        hit = rsp_hit;
        q   = rsp_data;
    endtask

    // Three reset-code writes with no other command between them
    task automatic reset_seq(output logic got);
        logic       h;
        logic [7:0] q;
        xfer(1'b1, ADDR_LOCK, {6'h00, RST_CODE_1}, got, h, q);
        xfer(1'b1, ADDR_LOCK, {6'h00, RST_CODE_2}, got, h, q);
        xfer(1'b1, ADDR_LOCK, {6'h00, RST_CODE_3}, got, h, q);
    endtask
endmodule // scl_master
`default_nettype wire

/* sim/testbench.sv */
// Self-checking testbench of the lock and OTP commit register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import scl_pkg::*;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       got;
        logic       hit;
        logic [7:0] data;
    } scl_row_t;
    // Ordinary accesses in DSI3 mode, die temperature held at 5a
    localparam scl_row_t ROWS [11] = '{
        '{1'b0, ADDR_LOCK, 8'h00, 1'b1, 1'b1, 8'h00}, '{1'b0, ADDR_OTP, 8'h00, 1'b1, 1'b1, 8'h00},
        '{1'b0, ADDR_REV, 8'h00, 1'b1, 1'b1, 8'h01}, '{1'b1, ADDR_REV, 8'hff, 1'b1, 1'b1, 8'h00},
        '{1'b0, ADDR_REV, 8'h00, 1'b1, 1'b1, 8'h01}, '{1'b0, ADDR_TEMP, 8'h00, 1'b1, 1'b1, 8'h5a},
        '{1'b1, ADDR_LOCK, 8'h08, 1'b1, 1'b1, 8'h00}, '{1'b0, ADDR_LOCK, 8'h00, 1'b1, 1'b1, 8'h08},
        '{1'b1, ADDR_OTP, 8'h7d, 1'b1, 1'b1, 8'h00}, '{1'b0, ADDR_OTP, 8'h00, 1'b1, 1'b1, 8'h0d},
        '{1'b0, 8'h20, 8'h00, 1'b1, 1'b0, 8'h00}};

    logic       clk, rstn, mode_dsi3, mode_psi5, psi5_diag, psi5_init3_exit, osc_err_in;
    logic [7:0] temp_value, rsp_data, q;
    logic       cmd_valid, cmd_write, rsp_valid, rsp_hit, got, hit;
    logic [7:0] cmd_addr, cmd_wdata;
    logic       init_done_lock, supply_fault_report_off, baseline_filter_final, selftest_inhibit;
    logic       pdcm_force, osc_training_fault, soft_reset_req, edc_fault, otp_commit_start;
    logic       skip_protocol_select, skip_location_code;
    logic [1:0] otp_region_select;
    logic [2:0] region_locked;
    logic [7:0] commit_cnt = 8'h00;
    logic [7:0] reset_cnt  = 8'h00;
    int         num_errors = 0;
    int         tests_run  = 0;

    scl_master scl_master_i (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit),
        .rsp_data(rsp_data));
    scl_regs scl_regs_i (.clk(clk), .rstn(rstn), .mode_dsi3(mode_dsi3), .mode_psi5(mode_psi5),
        .psi5_diag(psi5_diag), .psi5_init3_exit(psi5_init3_exit), .temp_value(temp_value),
        .osc_err_in(osc_err_in), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit),
        .rsp_data(rsp_data), .init_done_lock(init_done_lock),
        .supply_fault_report_off(supply_fault_report_off),
        .baseline_filter_final(baseline_filter_final), .selftest_inhibit(selftest_inhibit),
        .pdcm_force(pdcm_force), .osc_training_fault(osc_training_fault),
        .soft_reset_req(soft_reset_req), .edc_fault(edc_fault),
        .otp_commit_start(otp_commit_start), .otp_region_select(otp_region_select),
        .skip_protocol_select(skip_protocol_select), .skip_location_code(skip_location_code),
        .region_locked(region_locked));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Pulse counters; a pulse stuck high counts more than once
    always @(posedge clk)
    begin
        if (otp_commit_start === 1'b1) commit_cnt <= commit_cnt + 8'h01;
        if (soft_reset_req === 1'b1) reset_cnt <= reset_cnt + 8'h01;
    end

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("FAIL %0t value %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask

    task automatic complete_run;
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
        scl_master_i.xfer(w, a, d, got, hit, q);
    endtask

    task automatic set_mode(input logic d, input logic p, input logic g);
        @(posedge clk);
        mode_dsi3 <= d;
        mode_psi5 <= p;
        psi5_diag <= g;
    endtask

    // Reset held for 20 cycles, outputs checked at the first edge after release
    task automatic do_reset;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk1(init_done_lock, 1'b0);
        chk8({3'h0, edc_fault, rsp_valid, region_locked}, 8'h00);
    endtask

    // Watchdog: the whole sequence takes well under a thousand cycles
    initial
    begin
        #250000;
        num_errors++;
        complete_run();
    end

    initial
    begin
        rstn = 1'b0;
        {mode_dsi3, mode_psi5, psi5_diag, psi5_init3_exit, osc_err_in} = 5'b10000;
        temp_value = 8'h5a;
        do_reset();
        foreach (ROWS[i])
        begin
            cmd(ROWS[i].wr, ROWS[i].addr, ROWS[i].wdata);
            chk1(got, ROWS[i].got);
            chk1(hit, ROWS[i].hit);
            if (ROWS[i].hit) chk8(q, ROWS[i].data);
        end
        chk8(commit_cnt, 8'h00);
        chk1(supply_fault_report_off, 1'b1);
        // Commits: region 2, repeat on a locked region, reserved code, region 0 with skips
        cmd(1'b1, ADDR_OTP, 8'h82);
        chk8({otp_commit_start, 5'h00, otp_region_select}, 8'h82);
        cmd(1'b1, ADDR_OTP, 8'h82);
        chk1(otp_commit_start, 1'b0);
        chk1(edc_fault, 1'b0);
        cmd(1'b1, ADDR_OTP, 8'h83);
        chk1(otp_commit_start, 1'b0);
        cmd(1'b1, ADDR_OTP, 8'h8c);
        chk8({otp_commit_start, skip_protocol_select, skip_location_code, 5'h00}, 8'he0);
        chk8({5'h00, region_locked}, 8'h05);
        repeat (2) @(posedge clk);
        chk8(commit_cnt, 8'h02);
        chk1(edc_fault, 1'b1);
        // Soft reset: good sequence, then one broken by a read
        scl_master_i.reset_seq(got);
        chk1(soft_reset_req, 1'b1);
        cmd(1'b1, ADDR_LOCK, 8'h00);
        cmd(1'b0, ADDR_REV, 8'h00);
        cmd(1'b1, ADDR_LOCK, 8'h03);
        cmd(1'b1, ADDR_LOCK, 8'h01);
        repeat (2) @(posedge clk);
        chk8(reset_cnt, 8'h01);
        @(posedge clk);
        osc_err_in <= 1'b1;
        @(posedge clk);
        #1;
        chk1(osc_training_fault, 1'b1);
        // Access gating by mode, then lock in PSI5 diagnostic mode
        set_mode(1'b0, 1'b1, 1'b0);
        cmd(1'b0, ADDR_REV, 8'h00);
        chk1(got, 1'b0);
        set_mode(1'b0, 1'b1, 1'b1);
        cmd(1'b0, ADDR_REV, 8'h00);
        chk8(q, 8'h06);
        cmd(1'b1, ADDR_LOCK, 8'h88);
        cmd(1'b1, ADDR_LOCK, 8'h00);
        cmd(1'b1, ADDR_OTP, 8'h81);
        chk1(otp_commit_start, 1'b0);
        cmd(1'b0, ADDR_LOCK, 8'h00);
        chk8(q, 8'h88);
        chk8({baseline_filter_final, selftest_inhibit, pdcm_force, 5'h00}, 8'hc0);
        // Lock in DSI3 ends command responses
        do_reset();
        set_mode(1'b1, 1'b0, 1'b0);
        cmd(1'b1, ADDR_LOCK, 8'h80);
        cmd(1'b0, ADDR_REV, 8'h00);
        chk8({got, pdcm_force, 6'h00}, 8'h40);
        // PSI5 sets the lock itself on leaving init phase 3
        do_reset();
        set_mode(1'b0, 1'b1, 1'b0);
        @(posedge clk);
        psi5_init3_exit <= 1'b1;
        @(posedge clk);
        psi5_init3_exit <= 1'b0;
        #1;
        chk1(init_done_lock, 1'b1);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
